// File: rtl/psld_panel.v
// Front-panel status lamp driver for a managed industrial switch
//
// Function
// - System lamp steady green after self-check passed and system ready.
// - System lamp blinks green 1 Hz while reset button held.
// - After five seconds continuous hold, system lamp blinks green 4 Hz.
// - System lamp steady red on boot failure or info/nonvolatile read error.
// - Fault lamp steady red when alarm relay is triggered.
// - Fault lamp steady red when a port is shut down by ingress rate limit.
// - Fault lamp steady red on invalid ring port connection.
// - Fault lamp dark when no fault source is active.
// - Each power lamp amber while its own input is powered, else dark.
// - Ring lead lamp steady green for master, chain head or tree root.
// - Ring lead lamp blinks 4 Hz on ring or chain failure cases.
// - Coupling end lamp green when coupling, dual homing or chain tail.
// - Coupling end lamp blinks 4 Hz on chain tail failure cases.
// - Locator makes all non-power system lamps blink all colours at 2 Hz; port lamps unaffected.
// - File transfer rotates system green, fault, ring lead and coupling end lamps; disabled by default.
// - Copper upper lamp green at 100M link, 4 Hz on traffic, dark down.
// - Copper lower lamp amber at 10M link, 4 Hz on traffic, dark down.
// - Fiber lamp green on 100M link, 4 Hz on traffic, dark down.
`timescale 1ns/1ps
`include "psld_defs.vh"
module psld_panel #(
   parameter         NCOPPER      = 6,
   parameter         NFIBER       = 3,
   parameter         HALF_TICKS   = `PSLD_CLK_HZ / `PSLD_HALF_4HZ_DIV,
   parameter integer HOLD_TICKS   = `PSLD_HOLD_SEC * `PSLD_HALF_4HZ_DIV,
   parameter         XFER_ENABLE  = 0
) (
   // Clock and reset
   input  wire               clk,
   input  wire               rst_n,
   // System status
   input  wire               power_on_selfcheck_pass,
   input  wire               boot_fail,
   input  wire               reset_button,
   // Fault sources
   input  wire               relay_alarm,
   input  wire               rate_limit_shutdown,
   input  wire               ring_port_invalid,
   // Power inputs
   input  wire               power_input_a,
   input  wire               power_input_b,
   // Redundancy role and health
   input  wire               role_lead,
   input  wire               lead_master_after_fail,
   input  wire               lead_chain_head_fail,
   input  wire               lead_member_ring_port_down,
   input  wire               lead_head_end_port_down,
   input  wire               role_coupling,
   input  wire               role_chain_tail,
   input  wire               tail_chain_fail,
   input  wire               tail_end_port_down,
   // Locator and file transfer
   input  wire               locator_active,
   input  wire               file_xfer_active,
   // Copper ports
   input  wire [NCOPPER-1:0] copper_link_100,
   input  wire [NCOPPER-1:0] copper_link_10,
   input  wire [NCOPPER-1:0] copper_traffic,
   // Fiber ports
   input  wire [NFIBER-1:0]  fiber_link,
   input  wire [NFIBER-1:0]  fiber_traffic,
   // System lamps
   output reg                state_green,
   output reg                state_red,
   output reg                fault_red,
   output reg                power_in_a_lamp,
   output reg                power_in_b_lamp,
   output reg                ring_lead_lamp,
   output reg                coupling_end_lamp,
   output reg                locate_amber,
   // Port lamps
   output reg  [NCOPPER-1:0] copper_upper_green,
   output reg  [NCOPPER-1:0] copper_lower_amber,
   output reg  [NFIBER-1:0]  fiber_green
);
   localparam ROT_S = 3'h1;
   localparam ROT_F = 3'h2;
   localparam ROT_L = 3'h4;

   wire [2:0] blink;
   wire       tick;
   reg  [2:0] sync_btn;
   reg  [7:0] hold_cnt;
   reg  [2:0] rot;
   reg  [2:0] next_rot;
   wire       b1;
   wire       b2;
   wire       b4;
   wire       btn;
   wire       held_long;
   wire       xfer;
   reg        n_sg;
   reg        n_sr;
   reg        n_fr;
   reg        n_lead;
   reg        n_cpl;
   reg        n_amb;

   // Blink phase select: 1 when lamp is in its lit half
   function blink_of;
      input steady;
      input blinking;
      input phase;
      begin
         blink_of = blinking ? phase : steady;
      end
   endfunction

   psld_blink_gen #(
      .HALF_TICKS (HALF_TICKS),
      .CW         (32)
   ) u_blink (
      .clk   (clk),
      .rst_n (rst_n),
      .blink (blink),
      .tick  (tick)
   );

   assign b4 = blink[`PSLD_BLINK_4HZ_BIT];
   assign b2 = blink[`PSLD_BLINK_2HZ_BIT];
   assign b1 = blink[`PSLD_BLINK_1HZ_BIT];

   // Button comes from a pin: three stages, change once last two agree
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         sync_btn <= 3'h0;
      else
         sync_btn <= {sync_btn[1:0], reset_button};
   end
   reg btn_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         btn_q <= 1'b0;
      else if (sync_btn[2] == sync_btn[1])
         btn_q <= sync_btn[1];
   end
   assign btn = btn_q;

   // Hold time counted in eighth-second ticks; saturates at the limit
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         hold_cnt <= 8'h00;
      else if (!btn)
         hold_cnt <= 8'h00;
      else if (tick && hold_cnt != HOLD_TICKS[7:0])
         hold_cnt <= hold_cnt + 8'h01;
   end
   assign held_long = (hold_cnt == HOLD_TICKS[7:0]);

   // Rotation for file transfer, one step per 4 Hz period; lead and coupling lamps share the third step
   assign xfer = file_xfer_active && (XFER_ENABLE != 0);
   always @* begin
      case (rot)
         ROT_S:   next_rot = ROT_F;
         ROT_F:   next_rot = ROT_L;
         ROT_L:   next_rot = ROT_S;
         default: next_rot = ROT_S;
      endcase
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rot <= ROT_S;
      else if (!xfer)
         rot <= ROT_S;
      else if (tick && !b4)
         rot <= next_rot;
   end

   // Next system lamp values; override first, then blink over steady
   always @* begin
      n_amb  = 1'b0;
      n_sg   = 1'b0;
      n_sr   = 1'b0;
      n_fr   = 1'b0;
      n_lead = 1'b0;
      n_cpl  = 1'b0;
      if (locator_active) begin
         n_sg   = b2;
         n_sr   = b2;
         n_fr   = b2;
         n_lead = b2;
         n_cpl  = b2;
         n_amb  = b2;
      end else if (xfer) begin
         n_sg   = rot[0];
         n_fr   = rot[1];
         n_lead = rot[2];
         n_cpl  = rot[2];
      end else begin
         if (btn)
            n_sg = held_long ? b4 : b1;
         else if (boot_fail)
            n_sr = 1'b1;
         else
            n_sg = power_on_selfcheck_pass;
         n_fr = relay_alarm | rate_limit_shutdown | ring_port_invalid;
         n_lead = blink_of(role_lead,
                           lead_master_after_fail | lead_chain_head_fail |
                           lead_member_ring_port_down | lead_head_end_port_down, b4);
         n_cpl = blink_of(role_coupling | role_chain_tail,
                          tail_chain_fail | tail_end_port_down, b4);
      end
   end

   // All lamps registered; dark in reset
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_green        <= 1'b0;
         state_red          <= 1'b0;
         fault_red          <= 1'b0;
         power_in_a_lamp    <= 1'b0;
         power_in_b_lamp    <= 1'b0;
         ring_lead_lamp     <= 1'b0;
         coupling_end_lamp  <= 1'b0;
         locate_amber       <= 1'b0;
         copper_upper_green <= {NCOPPER{1'b0}};
         copper_lower_amber <= {NCOPPER{1'b0}};
         fiber_green        <= {NFIBER{1'b0}};
      end else begin
         state_green        <= n_sg;
         state_red          <= n_sr;
         fault_red          <= n_fr;
         power_in_a_lamp    <= power_input_a;
         power_in_b_lamp    <= power_input_b;
         ring_lead_lamp     <= n_lead;
         coupling_end_lamp  <= n_cpl;
         locate_amber       <= n_amb;
         // Traffic blinks only while the link at that speed is up
         copper_upper_green <= copper_link_100 & (copper_traffic & {NCOPPER{b4}} |
                               ~copper_traffic);
         copper_lower_amber <= copper_link_10 & (copper_traffic & {NCOPPER{b4}} |
                               ~copper_traffic);
         fiber_green        <= fiber_link & (fiber_traffic & {NFIBER{b4}} | ~fiber_traffic);
      end
   end
endmodule // psld_panel

// File: inc/psld_defs.vh
// Constants for the front-panel status lamp driver
`ifndef PSLD_DEFS_VH
`define PSLD_DEFS_VH
`define PSLD_CLK_HZ          25000000
`define PSLD_HOLD_SEC        5
`define PSLD_HALF_4HZ_DIV    8
`define PSLD_BLINK_1HZ_BIT   2
`define PSLD_BLINK_2HZ_BIT   1
`define PSLD_BLINK_4HZ_BIT   0
`define PSLD_ROT_STEPS       3
`define PSLD_SYNC_STAGES     3
`endif

// File: rtl/psld_blink_gen.v
// Shared blink-rate divider producing 4, 2 and 1 Hz square waves
`timescale 1ns/1ps
`include "psld_defs.vh"
module psld_blink_gen #(
   parameter         HALF_TICKS = 3125000,
   parameter integer CW         = 22
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Blink phases and eighth-second tick
   output reg  [2:0]   blink,
   output reg          tick
);
   reg [CW-1:0] count;

   // Terminal count sets the 4 Hz half period; slower rates double it in turn
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= {CW{1'b0}};
         blink <= 3'h0;
         tick  <= 1'b0;
      end else if (count == HALF_TICKS[CW-1:0] - 1'b1) begin
         count <= {CW{1'b0}};
         blink <= blink + 3'h1;
         tick  <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule // psld_blink_gen

// File: dv/psld_panel_checker.sv
// Assertion checker for the panel lamp driver
`timescale 1ns/1ps
module psld_panel_checker #(parameter NCOPPER = 6, parameter NFIBER = 3) (
   input wire               clk, rst_n, power_on_selfcheck_pass, boot_fail, reset_button, relay_alarm,
   input wire               rate_limit_shutdown, ring_port_invalid, power_input_a, locator_active,
   input wire               lead_member_ring_port_down, role_coupling, tail_chain_fail, tail_end_port_down,
   input wire               state_green, state_red, fault_red, power_in_a_lamp, ring_lead_lamp,
   input wire               coupling_end_lamp, locate_amber,
   input wire [NCOPPER-1:0] copper_link_100, copper_upper_green,
   input wire [NFIBER-1:0]  fiber_link, fiber_green
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Button synchroniser must be empty before steady patterns apply
   sequence s_btn_idle; !reset_button[*6]; endsequence
   sequence s_lead_fail; (lead_member_ring_port_down && !locator_active)[*8]; endsequence
   AST_RST_DARK: assert property (disable iff (1'b0) !rst_n |-> !(state_green | state_red | fault_red |
      ring_lead_lamp | coupling_end_lamp | locate_amber | power_in_a_lamp)) else $error("lamp lit in reset");
   AST_GREEN: assert property (s_btn_idle ##0 (power_on_selfcheck_pass && !boot_fail && !locator_active)
      |=> state_green && !state_red) else $error("state lamp not green");
   AST_RED: assert property (s_btn_idle ##0 (boot_fail && !locator_active) |=> state_red && !state_green)
      else $error("state lamp not red");
   AST_FAULT: assert property (!locator_active |=>
      fault_red == $past(relay_alarm | rate_limit_shutdown | ring_port_invalid)) else $error("fault lamp wrong");
   AST_PWR_A: assert property (1'b1 |=> power_in_a_lamp == $past(power_input_a)) else $error("power lamp wrong");
   AST_COUP: assert property (role_coupling && !tail_chain_fail && !tail_end_port_down && !locator_active
      |=> coupling_end_lamp) else $error("coupling lamp dark");
   AST_LEAD_BLINK: assert property (s_lead_fail ##0 $changed(ring_lead_lamp) |->
      $past(ring_lead_lamp, 4) == $past(ring_lead_lamp, 1) && $past(ring_lead_lamp, 5) != $past(ring_lead_lamp, 4))
      else $error("lead lamp blink period wrong");
   AST_LOCATE: assert property (locator_active[*2] |-> state_green == state_red && state_red == fault_red &&
      fault_red == ring_lead_lamp && ring_lead_lamp == coupling_end_lamp && coupling_end_lamp == locate_amber)
      else $error("locator lamps out of step");
   AST_CU_DARK: assert property (1'b1 |=> (copper_upper_green & ~$past(copper_link_100)) == '0)
      else $error("copper lamp lit without link");
   AST_FIB_DARK: assert property (1'b1 |=> (fiber_green & ~$past(fiber_link)) == '0)
      else $error("fiber lamp lit without link");
endmodule // psld_panel_checker
bind psld_panel psld_panel_checker #(.NCOPPER(NCOPPER), .NFIBER(NFIBER)) u_chk (.*);

// File: dv/psld_lamp_obs.sv
// Operator model: counts lamp turn-on events per lamp
`timescale 1ns/1ps
module psld_lamp_obs (
   input  wire        clk,
   input  wire        clear,
   input  wire  [7:0] lamps,
   output logic [7:0] rises [8]
);
   logic [7:0] prev = 8'h00;
   always @(posedge clk) begin
      prev <= lamps;
      for (int i = 0; i < 8; i++) rises[i] <= clear ? 8'h00 : rises[i] + {7'h00, lamps[i] & ~prev[i]};
   end
endmodule // psld_lamp_obs

// File: dv/psld_panel_tb.sv
// Self-checking bench for the panel lamp driver
`timescale 1ns/1ps
module psld_panel_tb;
   logic clk = 0, rst_n = 1, clear = 0, power_on_selfcheck_pass = 0, boot_fail = 0, reset_button = 0;
   logic relay_alarm = 0, rate_limit_shutdown = 0, ring_port_invalid = 0, power_input_a = 0, power_input_b = 0;
   logic role_lead = 0, lead_master_after_fail = 0, lead_chain_head_fail = 0, lead_member_ring_port_down = 0;
   logic lead_head_end_port_down = 0, role_coupling = 0, role_chain_tail = 0, tail_chain_fail = 0;
   logic tail_end_port_down = 0, locator_active = 0, file_xfer_active = 0;
   logic [5:0] copper_link_100 = 0, copper_link_10 = 0, copper_traffic = 0, copper_upper_green, copper_lower_amber;
   logic [2:0] fiber_link = 0, fiber_traffic = 0, fiber_green;
   logic state_green, state_red, fault_red, power_in_a_lamp, power_in_b_lamp, ring_lead_lamp, coupling_end_lamp;
   logic locate_amber;
   logic [7:0] rises [8];
   int mismatches = 0, n_tests = 0;
   always #20 clk = ~clk;
   psld_panel #(.HALF_TICKS(4), .HOLD_TICKS(16)) DUT (.*);
   psld_lamp_obs u_obs (.clk, .clear, .rises, .lamps({fiber_green[0], copper_upper_green[0], locate_amber,
      coupling_end_lamp, ring_lead_lamp, fault_red, state_red, state_green}));
   task automatic chk(input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Settle, then count turn-ons over 32 cycles, a whole number of blink periods
   task automatic win;
      repeat (3) @(posedge clk);
      clear <= 1;
      @(posedge clk);
      clear <= 0;
      repeat (32) @(posedge clk);
      #1;
   endtask
   task automatic t_sys;
      @(posedge clk);
      power_on_selfcheck_pass <= 1;
      win;
      chk({rises[0], state_green}, 1);
      @(posedge clk);
      boot_fail <= 1;
      win;
      chk({state_green, state_red}, 1);
      $display("system lamp test done");
   endtask
   task automatic t_fault;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {relay_alarm, rate_limit_shutdown, ring_port_invalid} <= 3'h1 << i;
         {power_input_a, power_input_b} <= i[1:0];
         repeat (3) @(posedge clk);
         #1;
         chk(fault_red, i < 3);
         chk({power_in_a_lamp, power_in_b_lamp}, i[1:0]);
      end
      $display("fault and power test done");
   endtask
   task automatic t_roles;
      @(posedge clk);
      {role_lead, role_coupling, role_chain_tail} <= 3'h7;
      win;
      chk({ring_lead_lamp, coupling_end_lamp}, 2'h3);
      chk({rises[3], rises[4]}, 16'h0000);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         {lead_master_after_fail, lead_chain_head_fail, lead_member_ring_port_down, lead_head_end_port_down,
            tail_chain_fail, tail_end_port_down} <= 6'h20 >> i;
         win;
         chk(rises[3], i < 4 ? 8'h04 : 8'h00);
         chk(rises[4], (i == 4 || i == 5) ? 8'h04 : 8'h00);
      end
      $display("role lamp test done");
   endtask
   task automatic t_loc;
      @(posedge clk);
      locator_active <= 1;
      win;
      for (int j = 0; j < 6; j++) chk(rises[j], 2);
      @(posedge clk);
      locator_active <= 0;
      file_xfer_active <= 1;
      win;
      chk({rises[3], ring_lead_lamp}, 1);
      $display("locator test done");
   endtask
   task automatic t_port;
      @(posedge clk);
      copper_link_100 <= 6'h01;
      copper_link_10 <= 6'h02;
      fiber_link <= 3'h1;
      win;
      chk({copper_upper_green, copper_lower_amber, fiber_green}, 15'h0211);
      @(posedge clk);
      copper_traffic <= 6'h3D;
      fiber_traffic <= 3'h7;
      win;
      chk({rises[6], rises[7]}, 16'h0404);
      chk({copper_upper_green[5:1], copper_lower_amber[5:2], fiber_green[2:1]}, 0);
      $display("port lamp test done");
   endtask
   task automatic t_btn;
      @(posedge clk);
      reset_button <= 1;
      repeat (4) @(posedge clk);
      win;
      chk(rises[0], 1);
      repeat (40) @(posedge clk);
      win;
      chk(rises[0], 4);
      @(posedge clk);
      reset_button <= 0;
      $display("button test done");
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      // Falling edge at time zero fires the asynchronous reset before the first clock
      rst_n <= 0;
      repeat (5) @(posedge clk);
      rst_n <= 1;
      t_sys;
      t_fault;
      t_roles;
      t_loc;
      t_port;
      t_btn;
      close_out;
   end
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      close_out;
   end
endmodule // psld_panel_tb
